// >>> hdl/cot_pkg.sv
// Package: constants, types and helpers for the constant off-time chopper
package cot_pkg;

  // ==========================================================
  // Register map, byte addresses
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] ADR_CFG = 8'h00;
  localparam logic [ADR_W-1:0] ADR_HIGH_VELOCITY_THRESHOLD = 8'h04;
  localparam logic [ADR_W-1:0] ADR_STATUS = 8'h08;

  // ==========================================================
  // Configuration word, bit 0 upward: mode, comparator disable,
  // random enable, hyst start (3), fast msb, hyst end (4),
  // slow decay (4), blank select (2), sync divide (4)
  typedef struct packed {
    logic [3:0] syncDivide;
    logic [1:0] blank_time_select;
    logic [3:0] slow_decay_time;
    logic [3:0] hyst_end_field;
    logic fast_decay_msb;
    logic [2:0] hyst_start_field;
    logic randomOffEnable;
    logic fastCmpDisable;
    logic modeConstOff;
  } cot_cfg_t;
  localparam int CFG_W = 21;
  localparam logic [CFG_W-1:0] CFG_RST = 21'h000000;

  typedef struct packed {
    logic onPh;
    logic fastPh;
    logic slowPh;
  } cot_drive_t;
  localparam cot_drive_t DRIVE_OFF = 3'h0;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ON = 5'b00010,
    ST_FAST = 5'b00100,
    ST_SLOW = 5'b01000,
    ST_WAIT = 5'b10000
  } cot_state_t;

  // ==========================================================
  // Timing
  localparam int CNT_W = 10;
  localparam logic [CNT_W-1:0] SLOW_BASE = 10'h018;
  localparam logic [CNT_W-1:0] SLOW_STEP = 10'h020;
  localparam logic [CNT_W-1:0] FAST_STEP = 10'h020;
  localparam logic [CNT_W-1:0] BLANK_CYC0 = 10'h010;
  localparam logic [CNT_W-1:0] BLANK_CYC1 = 10'h018;
  localparam logic [CNT_W-1:0] BLANK_CYC2 = 10'h024;
  localparam logic [CNT_W-1:0] BLANK_CYC3 = 10'h036;
  localparam logic [5:0] PRE_LAST = 6'h3F;
  localparam logic [3:0] OFFSET_ZERO = 4'h3;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS = 16'hB400;

  // ==========================================================
  // Helpers
  function automatic logic [CNT_W-1:0] fastCycles(input logic [3:0] s);
    return FAST_STEP * CNT_W'(s);
  endfunction

  function automatic logic [CNT_W-1:0] slowCycles(input logic [3:0] t,
                                                  input logic [3:0] r);
    return SLOW_BASE + SLOW_STEP * CNT_W'(t) + CNT_W'(r);
  endfunction

  function automatic logic [CNT_W-1:0] blankCycles(input logic [1:0] b);
    logic [CNT_W-1:0] c;
    unique case (b)
      2'h0: c = BLANK_CYC0;
      2'h1: c = BLANK_CYC1;
      2'h2: c = BLANK_CYC2;
      2'h3: c = BLANK_CYC3;
    endcase
    return c;
  endfunction

  function automatic cot_drive_t driveOf(input cot_state_t s);
    cot_drive_t d;
    d = DRIVE_OFF;
    unique case (s)
      ST_IDLE: d = DRIVE_OFF;
      ST_ON: d.onPh = 1'b1;
      ST_FAST: d.fastPh = 1'b1;
      ST_SLOW, ST_WAIT: d.slowPh = 1'b1;
      default: d = DRIVE_OFF;
    endcase
    return d;
  endfunction

  function automatic logic [31:0] byteMerge(input logic [31:0] old,
                                            input logic [31:0] wr,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = wr[8*i +: 8];
      end
    end
    return r;
  endfunction

endpackage

// >>> hdl/cot_coil.sv
// One coil's on / fast decay / slow decay sequencer
`timescale 1ns/1ns
`default_nettype none
module cot_coil (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire cot_pkg::cot_cfg_t cfg,
  input wire logic [3:0] rndAdd,
  input wire logic syncEn,
  input wire logic syncPulse,
  input wire logic compTrip,
  input wire logic negCmp,
  output var cot_pkg::cot_drive_t drive
);
  import cot_pkg::*;

  cot_state_t stateReg;
  cot_state_t stateNext;
  logic [CNT_W-1:0] phaseCntReg;
  logic [CNT_W-1:0] blankCntReg;
  logic [3:0] fastSel;
  logic blankDone;
  logic phaseDone;

  assign fastSel = {cfg.fast_decay_msb, cfg.hyst_start_field}; // [RULE_03]
  assign blankDone = (blankCntReg == '0);
  assign phaseDone = (phaseCntReg == '0);

  // ==========================================================
  // Phase sequencing
  always_comb begin
    stateNext = stateReg;
    unique case (stateReg)
      ST_IDLE: stateNext = ST_ON;
      ST_ON: begin
        if (blankDone && compTrip) begin // [RULE_02] [RULE_17]
          stateNext = (fastSel != 4'h0) ? ST_FAST : ST_SLOW; // [RULE_03]
        end
      end
      ST_FAST: begin
        if (phaseDone) begin // [RULE_02]
          stateNext = ST_SLOW;
        end else if (!cfg.fastCmpDisable && blankDone && negCmp) begin
          stateNext = ST_SLOW; // [RULE_05] [RULE_17]
        end
      end
      ST_SLOW: begin
        if (phaseDone) begin
          stateNext = syncEn ? ST_WAIT : ST_ON; // [RULE_09] [RULE_18]
        end
      end
      ST_WAIT: begin
        if (syncPulse || !syncEn) begin // [RULE_09] [RULE_18]
          stateNext = ST_ON;
        end
      end
      default: stateNext = ST_IDLE;
    endcase
    if (!enable) begin
      stateNext = ST_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stateReg <= ST_IDLE;
      drive <= DRIVE_OFF;
    end else begin
      stateReg <= stateNext;
      drive <= driveOf(stateNext);
    end
  end

  // ==========================================================
  // Phase timer, loaded on entry so a phase lasts exactly N cycles
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phaseCntReg <= '0;
    end else if (stateNext != stateReg && stateNext == ST_FAST) begin
      phaseCntReg <= fastCycles(fastSel) - 1'b1; // [RULE_03]
    end else if (stateNext != stateReg && stateNext == ST_SLOW) begin
      phaseCntReg <= slowCycles(cfg.slow_decay_time, rndAdd) - 1'b1; // [RULE_16]
    end else if (!phaseDone) begin
      phaseCntReg <= phaseCntReg - 1'b1;
    end
  end

  // ==========================================================
  // Blanking after each switch into the on or fast decay phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blankCntReg <= '0;
    end else if (stateNext != stateReg &&
                 (stateNext == ST_ON || stateNext == ST_FAST)) begin
      blankCntReg <= blankCycles(cfg.blank_time_select) - 1'b1; // [RULE_17]
    end else if (!blankDone) begin
      blankCntReg <= blankCntReg - 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/cot_chopper.sv
// Constant off-time chopper with sync stretcher and Wishbone registers
//
// Chosen here: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// RULE_01 - Mode bit: 0 leaves coils to hysteresis chopper, 1 runs constant off-time.
// RULE_02 - On phase ends at comparator trip and is followed by timed fast decay.
// RULE_03 - Fast decay length from fast msb and hyst start; zero means slow only.
// RULE_04 - Hyst end field gives signed sine offset, code 3 is zero.
// RULE_05 - Comparator may end fast decay early unless its disable bit is set.
// RULE_06 - Load-dependent fullstep operation forces constant off-time mode.
// RULE_07 - Without sync both coil choppers run independently.
// RULE_08 - Random enable adds pseudo-random cycles to each slow decay.
// RULE_09 - Sync only stretches off time, never shortens a cycle.
// RULE_10 - Sync is off while velocity exceeds the high-velocity threshold.
// RULE_11 - Sync field zero disables; N gives clock divided by 64 times N.
// RULE_12 - Software sets sync field to floor of fclk over 64 fsync.
// RULE_13 - Software picks sync at twice or equal to chopper frequency per mode.
// RULE_14 - Software keeps slow decay short so cycles end before sync pulse.
// RULE_15 - Sync has no effect while the voltage-mode quiet chopper runs.
// RULE_16 - Slow decay lasts 24 plus 32 times the setting in clocks.
// RULE_17 - Comparator is ignored during blanking after each switching event.
// RULE_18 - One shared free-running divider; finished coils wait for next pulse.
module cot_chopper #(
  parameter int VEL_W = 20
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cot_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [VEL_W-1:0] rampVelocity,
  input wire logic loadSpeedFullstep,
  input wire logic quietChopActive,
  input wire logic compTripA,
  input wire logic compTripB,
  input wire logic negCmpA,
  input wire logic negCmpB,
  output var cot_pkg::cot_drive_t coilDriveA,
  output var cot_pkg::cot_drive_t coilDriveB,
  output logic signed [4:0] sineOffset,
  output logic constOffActive,
  output logic syncActive
);
  import cot_pkg::*;

  generate
    if (VEL_W < 1 || VEL_W > 32) begin : g_bad_width
      $error("VEL_W must lie between 1 and 32");
    end
  endgenerate

  cot_cfg_t cfgReg;
  logic [VEL_W-1:0] vhighReg;
  logic [5:0] preCntReg;
  logic [3:0] divCntReg;
  logic syncPulseReg;
  logic [15:0] lfsrReg;
  logic wbHit;
  logic wbWrite;
  logic effMode;
  logic velAbove;
  logic syncWanted;
  logic [3:0] fastSel;
  logic [3:0] rndA;
  logic [3:0] rndB;
  logic [31:0] readData;
  logic [31:0] vhighWord;
  logic [31:0] cfgWrite;
  logic [31:0] vhighWrite;
  logic [CNT_W-1:0] slowLenReg;
  logic slowOkReg;
  cot_cfg_t lastCfgReg;

  // ==========================================================
  // Wishbone slave, one wait state, unmapped reads zero
  assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wbWrite = wbHit && wb_we_i;
  assign vhighWord = 32'(vhighReg);
  assign cfgWrite = byteMerge(32'(cfgReg), wb_dat_i, wb_sel_i);
  assign vhighWrite = byteMerge(vhighWord, wb_dat_i, wb_sel_i);

  always_comb begin
    readData = 32'h00000000;
    unique case (wb_adr_i)
      ADR_CFG: readData = 32'(cfgReg);
      ADR_HIGH_VELOCITY_THRESHOLD: readData = vhighWord;
      ADR_STATUS: readData = {18'h00000, syncPulseReg, syncActive,
                              constOffActive, coilDriveB, coilDriveA,
                              sineOffset};
      default: readData = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wbHit;
      if (wbHit && !wb_we_i) begin
        wb_dat_o <= readData;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cfgReg <= CFG_RST;
    end else if (wbWrite && wb_adr_i == ADR_CFG) begin
      cfgReg <= cfgWrite[CFG_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      vhighReg <= '0;
    end else if (wbWrite && wb_adr_i == ADR_HIGH_VELOCITY_THRESHOLD) begin
      vhighReg <= vhighWrite[VEL_W-1:0];
    end
  end

  // ==========================================================
  // Mode and offset
  assign effMode = cfgReg.modeConstOff || loadSpeedFullstep; // [RULE_01] [RULE_06]
  assign fastSel = {cfgReg.fast_decay_msb, cfgReg.hyst_start_field};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      constOffActive <= 1'b0;
      sineOffset <= 5'sh00;
    end else begin
      constOffActive <= effMode; // [RULE_01]
      if (effMode) begin
        sineOffset <= $signed({1'b0, cfgReg.hyst_end_field}) -
                      $signed({1'b0, OFFSET_ZERO}); // [RULE_04]
      end else begin
        sineOffset <= 5'sh00;
      end
    end
  end

  // ==========================================================
  // Shared sync divider and enable
  assign velAbove = rampVelocity > vhighReg;
  assign syncWanted = (cfgReg.syncDivide != 4'h0) && !velAbove && // [RULE_10]
                      !quietChopActive && effMode; // [RULE_15]

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      preCntReg <= 6'h00;
      divCntReg <= 4'h0;
      syncPulseReg <= 1'b0;
    end else begin
      preCntReg <= preCntReg + 6'h01; // [RULE_18]
      syncPulseReg <= 1'b0;
      if (cfgReg.syncDivide == 4'h0) begin // [RULE_11]
        divCntReg <= 4'h0;
      end else if (preCntReg == PRE_LAST) begin
        if (divCntReg >= cfgReg.syncDivide - 4'h1) begin
          divCntReg <= 4'h0;
          syncPulseReg <= 1'b1; // [RULE_11]
        end else begin
          divCntReg <= divCntReg + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      syncActive <= 1'b0;
    end else begin
      syncActive <= syncWanted; // [RULE_10] [RULE_15]
    end
  end

  // ==========================================================
  // Off-time randomiser
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lfsrReg <= LFSR_SEED;
    end else if (lfsrReg[0]) begin
      lfsrReg <= (lfsrReg >> 1) ^ LFSR_TAPS; // [RULE_08]
    end else begin
      lfsrReg <= lfsrReg >> 1;
    end
  end

  assign rndA = cfgReg.randomOffEnable ? lfsrReg[3:0] : 4'h0; // [RULE_08]
  assign rndB = cfgReg.randomOffEnable ? lfsrReg[11:8] : 4'h0;

  // ==========================================================
  // Two independent coil sequencers
  cot_coil u_coil_a ( // [RULE_07]
    .clk(clk),
    .rst_b(rst_b),
    .enable(constOffActive),
    .cfg(cfgReg),
    .rndAdd(rndA),
    .syncEn(syncActive),
    .syncPulse(syncPulseReg),
    .compTrip(compTripA),
    .negCmp(negCmpA),
    .drive(coilDriveA)
  );

  cot_coil u_coil_b (
    .clk(clk),
    .rst_b(rst_b),
    .enable(constOffActive),
    .cfg(cfgReg),
    .rndAdd(rndB),
    .syncEn(syncActive),
    .syncPulse(syncPulseReg),
    .compTrip(compTripB),
    .negCmp(negCmpB),
    .drive(coilDriveB)
  );

  // ==========================================================
  // Checks
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      slowLenReg <= '0;
    end else if (coilDriveA.slowPh) begin
      slowLenReg <= slowLenReg + 1'b1;
    end else begin
      slowLenReg <= '0;
    end
  end

  // Slow phase counts only if nothing disturbed its length
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lastCfgReg <= CFG_RST;
      slowOkReg <= 1'b0;
    end else begin
      lastCfgReg <= cfgReg;
      if (!coilDriveA.slowPh) begin
        slowOkReg <= 1'b1;
      end else if (syncActive || cfgReg.randomOffEnable ||
                   !constOffActive || cfgReg != lastCfgReg) begin
        slowOkReg <= 1'b0;
      end
    end
  end

  a_ack_single: assert property (@(posedge clk) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

  a_mode_select: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_01]
    constOffActive == $past(effMode)) else $error("mode not followed");

  a_offset_zero: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_04]
    effMode && cfgReg.hyst_end_field == 4'h3 |=> sineOffset == 5'sh00)
    else $error("offset code 3 not zero");

  a_on_then_fast: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_02]
    $fell(coilDriveA.onPh) && constOffActive && $past(constOffActive)
    |-> $past(compTripA) && (coilDriveA.fastPh || coilDriveA.slowPh))
    else $error("on phase ended without trip");

  a_fast_skip: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_03]
    $rose(coilDriveA.fastPh) |-> $past(fastSel) != 4'h0)
    else $error("fast decay with zero setting");

  a_slow_length: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_16]
    $fell(coilDriveA.slowPh) && constOffActive && !syncActive &&
    !cfgReg.randomOffEnable && $stable(cfgReg) && slowOkReg
    |-> slowLenReg == slowCycles(cfgReg.slow_decay_time, 4'h0))
    else $error("slow decay length wrong");

  a_sync_wait: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_09]
    $rose(coilDriveA.onPh) && $past(syncActive) && $past(coilDriveA.slowPh)
    |-> $past(syncPulseReg)) else $error("on phase started off sync");

  a_sync_period: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_11]
    syncPulseReg && cfgReg.syncDivide == 4'h1
    |-> ##64 (syncPulseReg || cfgReg.syncDivide != 4'h1))
    else $error("sync period not 64");

  a_sync_off: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_11]
    cfgReg.syncDivide == 4'h0 |=> !syncPulseReg)
    else $error("sync pulse while disabled");

  a_high_velocity_threshold_off: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_10]
    rampVelocity > vhighReg |=> !syncActive)
    else $error("sync above velocity threshold");

  a_quiet_off: assert property (@(posedge clk) disable iff (!rst_b) // [RULE_15]
    quietChopActive |=> !syncActive)
    else $error("sync during quiet chopper");

endmodule
`default_nettype wire

// >>> dv/cot_coil_model.sv
// Comparator stand-in for one coil of the power stage
`timescale 1ns/1ns
`default_nettype none
module cot_coil_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire cot_pkg::cot_drive_t drive,
  input wire logic [9:0] onLen,
  input wire logic negEn,
  input wire logic [9:0] negLen,
  output logic compTrip,
  output logic negCmp
);
  import cot_pkg::*;
  cot_drive_t prevDrive;
  logic [9:0] phaseCnt;
  // Cycles spent in the present phase
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prevDrive <= DRIVE_OFF;
      phaseCnt <= 10'h000;
    end else begin
      prevDrive <= drive;
      phaseCnt <= (drive != prevDrive) ? 10'h000 : phaseCnt + 10'h001;
    end
  end
  // Both lines sit high outside their phase, so they must be ignored
  assign compTrip = !drive.onPh || (phaseCnt >= onLen);
  assign negCmp = !drive.fastPh || (negEn && phaseCnt >= negLen);
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// Self-checking bench for the constant off-time chopper
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
  err_total++; $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module tb_top;
  import cot_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDat = 32'h00000000;
  logic [31:0] wbDatO;
  logic wbAck;
  logic [19:0] rampVel = 20'h00064;
  logic loadFull = 1'b0;
  logic quiet = 1'b0;
  logic [9:0] onLenA = 10'h01E;
  logic [9:0] onLenB = 10'h03C;
  logic negEn = 1'b1;
  logic [9:0] negLen = 10'h005;
  logic tripA, tripB, negA, negB;
  cot_drive_t coilDriveA, coilDriveB;
  logic signed [4:0] sineOffset;
  logic constOffActive, syncActive;
  int err_total = 0;
  int n_tests = 0;
  cot_drive_t drv[2], prv[2], afterOn[2];
  int cnt[2], lenOn[2], lenFast[2], lenSlow[2], onAt[2], period[2];
  int cycN = 0;

  always #2 clk = ~clk;

  cot_chopper u_dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .rampVelocity(rampVel), .loadSpeedFullstep(loadFull),
    .quietChopActive(quiet), .compTripA(tripA), .compTripB(tripB),
    .negCmpA(negA), .negCmpB(negB), .coilDriveA(coilDriveA),
    .coilDriveB(coilDriveB), .sineOffset(sineOffset),
    .constOffActive(constOffActive), .syncActive(syncActive));
  cot_coil_model u_modA (.clk(clk), .rst_b(rst_b), .drive(coilDriveA),
    .onLen(onLenA), .negEn(negEn), .negLen(negLen), .compTrip(tripA),
    .negCmp(negA));
  cot_coil_model u_modB (.clk(clk), .rst_b(rst_b), .drive(coilDriveB),
    .onLen(onLenB), .negEn(negEn), .negLen(negLen), .compTrip(tripB),
    .negCmp(negB));

  // ==========================================================
  // Phase length monitor for both coils
  assign drv[0] = coilDriveA;
  assign drv[1] = coilDriveB;
  always @(posedge clk) begin
    cycN++;
    for (int i = 0; i < 2; i++) begin
      if (drv[i] !== prv[i]) begin
        if (prv[i].onPh) begin
          lenOn[i] = cnt[i];
          afterOn[i] = drv[i];
        end
        if (prv[i].fastPh) lenFast[i] = cnt[i];
        if (prv[i].slowPh) lenSlow[i] = cnt[i];
        if (drv[i].onPh) begin
          period[i] = cycN - onAt[i];
          onAt[i] = cycN;
        end
        cnt[i] = 1;
      end else cnt[i]++;
      prv[i] = drv[i];
    end
  end

  // ==========================================================
  // Bus and helper tasks
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDat <= d;
    wbSel <= s;
    do begin
      @(posedge clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    `CHK("bus ack", 1'b1, wbAck)
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, 4'hF, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    wb(1'b0, a, 32'h00000000, 4'h0, q);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [31:0] cfgw(logic m, logic cd, logic rn,
      logic [3:0] f, logic [3:0] he, logic [3:0] t, logic [1:0] b,
      logic [3:0] sy);
    cot_cfg_t c;
    c = {sy, b, t, he, f[3], f[2:0], rn, cd, m};
    return {11'h000, c};
  endfunction

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    logic [31:0] q;
    rd(ADR_CFG, q); `CHK("cfg reset", 32'h00000000, q)
    rd(ADR_HIGH_VELOCITY_THRESHOLD, q); `CHK("high_velocity_threshold reset", 32'h00000000, q)
    rd(ADR_STATUS, q); `CHK("status reset", 32'h00000000, q)
    rd(8'h0C, q); `CHK("unmapped", 32'h00000000, q)
    wr(ADR_HIGH_VELOCITY_THRESHOLD, 32'hFFFFFFFF);
    rd(ADR_HIGH_VELOCITY_THRESHOLD, q); `CHK("high_velocity_threshold rw", 32'h000FFFFF, q)
    wb(1'b1, ADR_CFG, 32'hFFFFFFFF, 4'h1, q);
    rd(ADR_CFG, q); `CHK("cfg byte", 32'h000000FF, q)
    wr(ADR_CFG, 32'h00000000);
    wr(ADR_STATUS, 32'hFFFFFFFF);
    rd(ADR_STATUS, q); `CHK("status ro", 32'h00000000, q)
    $display("test regs done");
  endtask

  task automatic t_offset;
    logic [31:0] q;
    logic [3:0] h[3] = '{4'h0, 4'h3, 4'hF};
    for (int i = 0; i < 3; i++) begin
      wr(ADR_CFG, cfgw(1, 1, 0, 4'h1, h[i], 4'h0, 2'h0, 4'h0));
      settle(3);
      `CHK("offset", 5'(h[i]) - 5'h03, sineOffset)
    end
    rd(ADR_STATUS, q); `CHK("mode on", 1'b1, q[11])
    wr(ADR_CFG, cfgw(0, 1, 0, 4'h1, 4'hF, 4'h0, 2'h0, 4'h0));
    settle(3);
    `CHK("offset off", 5'h00, sineOffset)
    `CHK("mode off", 1'b0, constOffActive)
    `CHK("drive off", DRIVE_OFF, coilDriveA)
    $display("test offset done");
  endtask

  task automatic t_timing;
    int f[3] = '{2, 15, 0};
    int t[3] = '{1, 0, 15};
    for (int i = 0; i < 3; i++) begin
      wr(ADR_CFG, cfgw(1, 1, 0, f[i], 4'h3, t[i], 2'h0, 4'h0));
      settle(2500);
      if (f[i] != 0) `CHK("fast len", 32 * f[i], lenFast[0])
      `CHK("after on", f[i] != 0 ? 3'h2 : 3'h1, afterOn[0])
      `CHK("slow len", 24 + 32 * t[i], lenSlow[0])
      `CHK("slow len b", 24 + 32 * t[i], lenSlow[1])
      `CHK("on a", 1'b1, lenOn[0] >= 30 && lenOn[0] <= 34)
      `CHK("on b", 1'b1, lenOn[1] >= 60 && lenOn[1] <= 64)
    end
    $display("test timing done");
  endtask

  task automatic t_cmpterm;
    int bl[4] = '{16, 24, 36, 54};
    @(posedge clk);
    negLen <= 10'h028;
    wr(ADR_CFG, cfgw(1, 0, 0, 4'hF, 4'h3, 4'h0, 2'h0, 4'h0));
    settle(1500);
    `CHK("fast early", 1'b1, lenFast[0] >= 40 && lenFast[0] <= 44)
    @(posedge clk);
    negLen <= 10'h000;
    onLenA <= 10'h000;
    for (int b = 0; b < 4; b++) begin
      wr(ADR_CFG, cfgw(1, 0, 0, 4'hF, 4'h3, 4'h0, b, 4'h0));
      settle(800);
      `CHK("on blank", 1'b1, lenOn[0] >= bl[b] && lenOn[0] <= bl[b] + 3)
      `CHK("fast blank", 1'b1, lenFast[0] >= bl[b] && lenFast[0] <= bl[b] + 3)
    end
    @(posedge clk);
    negLen <= 10'h005;
    onLenA <= 10'h01E;
    $display("test comparator done");
  endtask

  task automatic t_random;
    int mn, mx, at, n;
    mn = 999;
    mx = 0;
    wr(ADR_CFG, cfgw(1, 1, 1, 4'h1, 4'h3, 4'h0, 2'h0, 4'h0));
    settle(300);
    repeat (8) begin
      at = onAt[0];
      n = 0;
      while (onAt[0] == at && n < 400) begin
        settle(1);
        n++;
      end
      if (lenSlow[0] < mn) mn = lenSlow[0];
      if (lenSlow[0] > mx) mx = lenSlow[0];
    end
    `CHK("rnd range", 1'b1, mn >= 24 && mx <= 39)
    `CHK("rnd varies", 1'b1, mx != mn)
    $display("test random done");
  endtask

  task automatic t_sync;
    int nn[2] = '{1, 3};
    for (int i = 0; i < 2; i++) begin
      // Short slow decay, field from clock over 64 sync
      wr(ADR_CFG, cfgw(1, 1, 0, 4'h1, 4'h3, 4'h0, 2'h0, nn[i]));
      settle(1200);
      `CHK("sync on", 1'b1, syncActive)
      `CHK("period a", 0, period[0] % (64 * nn[i]))
      `CHK("period b", 0, period[1] % (64 * nn[i]))
      `CHK("stretch", 1'b1, period[0] >= lenOn[0] + lenFast[0] + 24)
    end
    wr(ADR_HIGH_VELOCITY_THRESHOLD, 32'h00000064);
    @(posedge clk);
    rampVel <= 20'h00065;
    settle(600);
    `CHK("vel above", 1'b0, syncActive)
    `CHK("unstretched", 24, lenSlow[0])
    @(posedge clk);
    rampVel <= 20'h00064;
    settle(3);
    `CHK("vel equal", 1'b1, syncActive)
    @(posedge clk);
    quiet <= 1'b1;
    settle(600);
    `CHK("quiet", 1'b0, syncActive)
    `CHK("quiet slow", 24, lenSlow[0])
    @(posedge clk);
    quiet <= 1'b0;
    wr(ADR_CFG, cfgw(1, 1, 0, 4'h1, 4'h3, 4'h0, 2'h0, 4'h0));
    settle(3);
    `CHK("sync zero", 1'b0, syncActive)
    $display("test sync done");
  endtask

  task automatic t_fullstep;
    wr(ADR_CFG, cfgw(0, 1, 0, 4'h2, 4'h3, 4'h1, 2'h0, 4'h0));
    loadFull <= 1'b1;
    settle(1500);
    `CHK("forced mode", 1'b1, constOffActive)
    `CHK("forced fast", 64, lenFast[0])
    loadFull <= 1'b0;
    settle(3);
    `CHK("released", DRIVE_OFF, coilDriveA)
    $display("test fullstep done");
  endtask

  task automatic test_done;
    $display("tests %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    test_done();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_regs();
    t_offset();
    t_timing();
    t_cmpterm();
    t_random();
    t_sync();
    t_fullstep();
    test_done();
  end
endmodule
`default_nettype wire
